// >>> logic/ttc_pkg.sv
package ttc_pkg;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_RUN_FLAG = 8'h88;    // timer_run_flag_register
  localparam logic [7:0] ADDR_MODE = 8'h89;        // timer_mode_register
  localparam logic [7:0] ADDR_T0_LOW = 8'h8a;      // t0_low_byte
  localparam logic [7:0] ADDR_T1_LOW = 8'h8b;      // t1_low_byte
  localparam logic [7:0] ADDR_T0_HIGH = 8'h8c;     // t0_high_byte
  localparam logic [7:0] ADDR_T1_HIGH = 8'h8d;     // t1_high_byte
  localparam logic [7:0] ADDR_CLK_SELECT = 8'h8e;  // timer_clock_select

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [5:0] RST_CLK_SELECT = 6'h00;
  localparam logic [7:0] RST_RUN_FLAG = 8'h00;
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [7:0] RST_COUNT = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CKS_T2_HIGH = 5;   // t2_high_system_clock_select
  localparam int CKS_T2_LOW = 4;    // t2_low_system_clock_select
  localparam int CKS_T1 = 3;        // t1_system_clock_select
  localparam int CKS_T0 = 2;        // t0_system_clock_select
  localparam int CKS_PRE_HI = 1;    // prescale_select msb
  localparam int CKS_PRE_LO = 0;    // prescale_select lsb
  localparam int RF_T1_FLAG = 7;    // t1_overflow_flag
  localparam int RF_T1_RUN = 6;     // t1_run
  localparam int RF_T0_FLAG = 5;    // t0_overflow_flag
  localparam int RF_T0_RUN = 4;     // t0_run
  localparam int MD_T1_GATE = 7;    // t1_gate_enable
  localparam int MD_T1_CNT = 6;     // t1_counter_select
  localparam int MD_T1_HI = 5;      // t1 mode msb
  localparam int MD_T1_LO = 4;      // t1 mode lsb
  localparam int MD_T0_GATE = 3;    // t0_gate_enable
  localparam int MD_T0_CNT = 2;     // t0_counter_select
  localparam int MD_T0_HI = 1;      // t0 mode msb
  localparam int MD_T0_LO = 0;      // t0 mode lsb

  // ----------------------------------------------------------------
  // Mode and prescale encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_13BIT = 2'h0;
  localparam logic [1:0] MODE_16BIT = 2'h1;
  localparam logic [1:0] MODE_RELOAD = 2'h2;
  localparam logic [1:0] MODE_SPLIT = 2'h3;
  localparam logic [1:0] PRE_DIV12 = 2'h0;
  localparam logic [1:0] PRE_DIV4 = 2'h1;
  localparam logic [1:0] PRE_DIV48 = 2'h2;
  localparam logic [1:0] PRE_EXT8 = 2'h3;

  // ----------------------------------------------------------------
  // Divider counts
  // ----------------------------------------------------------------
  localparam int DIV_A = 12;
  localparam int DIV_B = 4;
  localparam int DIV_C = 48;
  localparam int DIV_EXT = 8;
  localparam logic [5:0] PRE_LAST = 6'(DIV_C - 1);
  localparam logic [2:0] EXT_LAST = 3'(DIV_EXT - 1);

endpackage : ttc_pkg

// >>> logic/ttc_pin_sync.sv
`timescale 1ns/100ps

module ttc_pin_sync (
  input wire logic clock,  // System clock
  input wire logic rst_b,  // Async reset, active low
  input wire logic pin,    // Asynchronous pin level
  output logic level,      // Filtered level
  output logic fell,       // One-cycle pulse on high-to-low
  output logic rose        // One-cycle pulse on low-to-high
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
    logic fell;
    logic rose;
  } ttc_sync_s;

  ttc_sync_s st;
  ttc_sync_s next_st;

  // ----------------------------------------------------------------
  // Three-stage capture, change accepted once stages two and three agree
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.s1 = pin;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    if (st.s2 == st.s3) begin
      next_st.lvl = st.s3;
    end
    next_st.fell = st.lvl & ~next_st.lvl;  // [R23]
    next_st.rose = ~st.lvl & next_st.lvl;
  end

  // State register
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign level = st.lvl;
  assign fell = st.fell;
  assign rose = st.rose;

endmodule : ttc_pin_sync

// >>> logic/ttc_timer01.sv
// Functional notes
// [R1] Counter mode counts each falling count-pin edge
// [R2] Count pin levels held two clocks minimum
// [R3] Prescale field picks /12, /4, /48, ext/8
// [R4] Timer 1 clock-select bit: prescaled or system
// [R5] Timer 0 clock-select bit: prescaled or system
// [R6] Clock-select bits 7:6 read zero
// [R7] Bits 5,4 pick timer 2 clocks
// [R8] 13-bit mode: high byte plus low five
// [R9] 13-bit wrap sets overflow flag
// [R10] Run bit and gate decide advancing
// [R11] Run bit never clears or reloads count
// [R12] Timer 1 mirrors timer 0, own controls
// [R13] 16-bit mode uses both bytes
// [R14] Auto-reload: low byte reloads from high
// [R15] Software preloads low byte before reload
// [R16] Split mode low byte uses timer 0 controls
// [R17] Split high byte: timer 1 run, flag
// [R18] Split: timer 1 internal only, no flag
// [R19] Timer 1 stops in mode three
// [R20] Requests forwarded only when enabled
// [R21] Mode field encodings 00,01,10,11
// [R22] Flags set by overflow, cleared by software/ack
// [R23] Count pins synchronised, falling edge pulses
// [R24] All clock choices are system-clock enables
`timescale 1ns/100ps

module ttc_timer01 import ttc_pkg::*; (
  input wire logic clock,               // System clock, 10 MHz
  input wire logic rst_b,               // Async reset, active low
  input wire logic [7:0] sfr_addr,      // Register address
  input wire logic sfr_wr,              // Write strobe
  input wire logic sfr_rd,              // Read strobe
  input wire logic [7:0] sfr_wdata,     // Write data
  output logic [7:0] sfr_rdata,         // Read data, one cycle after strobe
  input wire logic t0_count_pin,        // Timer 0 event pin
  input wire logic t1_count_pin,        // Timer 1 event pin
  input wire logic ext_irq0_input,      // Timer 0 gate pin
  input wire logic ext_irq1_input,      // Timer 1 gate pin
  input wire logic external_osc_clock,  // External clock, sampled
  input wire logic ext_irq0_polarity,   // 1: gate 0 active high
  input wire logic ext_irq1_polarity,   // 1: gate 1 active high
  input wire logic t0_irq_enable,       // Timer 0 interrupt enable
  input wire logic t1_irq_enable,       // Timer 1 interrupt enable
  input wire logic t0_irq_ack,          // Vector taken, clears timer 0 flag
  input wire logic t1_irq_ack,          // Vector taken, clears timer 1 flag
  output logic t0_irq_req,              // Timer 0 interrupt request
  output logic t1_irq_req,              // Timer 1 interrupt request
  output logic t1_overflow_tick,        // Timer 1 overflow pulse for peripherals
  output logic prescaled_tick,          // Shared prescaled tick pulse
  output logic t2_high_system_clock_select,   // Timer 2 high byte uses system clock
  output logic t2_low_system_clock_select     // Timer 2 low/full uses system clock
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [5:0] clk_sel;
    logic [7:0] run_flag;
    logic [7:0] mode;
    logic [7:0] t0_low;
    logic [7:0] t0_high;
    logic [7:0] t1_low;
    logic [7:0] t1_high;
    logic [5:0] pre_cnt;
    logic [2:0] ext_cnt;
    logic pre_tick;
    logic t1_ovf;
    logic [7:0] rdata;
  } ttc_state_s;

  ttc_state_s st;
  ttc_state_s next_st;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic t0_pin_fell;
  logic t1_pin_fell;
  logic t0_gate_enable_level;
  logic t1_gate_enable_level;
  logic ext_rose;

  // Timer 0 event pin
  ttc_pin_sync u_sync_t0 (
    .clock(clock),
    .rst_b(rst_b),
    .pin(t0_count_pin),
    .level(),
    .fell(t0_pin_fell),
    .rose()
  );

  // Timer 1 event pin
  ttc_pin_sync u_sync_t1 (
    .clock(clock),
    .rst_b(rst_b),
    .pin(t1_count_pin),
    .level(),
    .fell(t1_pin_fell),
    .rose()
  );

  // Timer 0 gate pin
  ttc_pin_sync u_sync_g0 (
    .clock(clock),
    .rst_b(rst_b),
    .pin(ext_irq0_input),
    .level(t0_gate_enable_level),
    .fell(),
    .rose()
  );

  // Timer 1 gate pin
  ttc_pin_sync u_sync_g1 (
    .clock(clock),
    .rst_b(rst_b),
    .pin(ext_irq1_input),
    .level(t1_gate_enable_level),
    .fell(),
    .rose()
  );

  // External clock, counted on rising edges
  ttc_pin_sync u_sync_ext (
    .clock(clock),
    .rst_b(rst_b),
    .pin(external_osc_clock),
    .level(),
    .fell(),
    .rose(ext_rose)
  );

  // ----------------------------------------------------------------
  // Counting step for modes 0..2: returns {overflow, high, low}
  // ----------------------------------------------------------------
  function automatic logic [16:0] count_step(
    input logic [1:0] md,
    input logic [7:0] hi,
    input logic [7:0] lo,
    input logic inc
  );
    logic [12:0] c13;
    logic [15:0] c16;
    logic [7:0] c8;
    logic [16:0] res;
    c13 = {hi, lo[4:0]};
    c16 = {hi, lo};
    c8 = lo;
    res = {1'b0, hi, lo};
    if (inc) begin
      case (md)
        MODE_13BIT: begin  // [R21]
          res[16] = &c13;  // [R9]
          c13 = c13 + 13'h1;
          res[15:0] = {c13[12:5], lo[7:5], c13[4:0]};  // [R8]
        end
        MODE_16BIT: begin
          res[16] = &c16;  // [R13]
          c16 = c16 + 16'h1;
          res[15:0] = c16;
        end
        MODE_RELOAD: begin
          res[16] = &c8;  // [R14]
          c8 = c8 + 8'h1;
          res[15:0] = {hi, (&lo) ? hi : c8};  // [R14]
        end
        default: res = {1'b0, hi, lo};
      endcase
    end
    return res;
  endfunction : count_step

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic [1:0] t0_mode;
    logic [1:0] t1_mode;
    logic split;
    logic pre_pulse;
    logic g0_active;
    logic g1_active;
    logic t0_run;
    logic t1_run;
    logic t0_tick;
    logic t1_tick;
    logic h0_tick;
    logic h0_inc;
    logic t0_set;
    logic t1_set;
    logic t1_wrap;
    logic [16:0] r0;
    logic [16:0] r1;
    logic [7:0] rd;
    t0_mode = 2'h0;
    t1_mode = 2'h0;
    split = 1'b0;
    pre_pulse = 1'b0;
    g0_active = 1'b0;
    g1_active = 1'b0;
    t0_run = 1'b0;
    t1_run = 1'b0;
    t0_tick = 1'b0;
    t1_tick = 1'b0;
    h0_tick = 1'b0;
    h0_inc = 1'b0;
    t0_set = 1'b0;
    t1_set = 1'b0;
    t1_wrap = 1'b0;
    r0 = '0;
    r1 = '0;
    rd = 8'h00;
    next_st = st;

    t0_mode = st.mode[MD_T0_HI:MD_T0_LO];
    t1_mode = st.mode[MD_T1_HI:MD_T1_LO];
    split = (t0_mode == MODE_SPLIT);

    // Prescaler: one free counter over 48 clocks, ext clock over 8 edges
    next_st.pre_cnt = (st.pre_cnt == PRE_LAST) ? 6'h00 : st.pre_cnt + 6'h1;
    next_st.ext_cnt = st.ext_cnt + {2'h0, ext_rose};
    case (st.clk_sel[CKS_PRE_HI:CKS_PRE_LO])  // [R3]
      PRE_DIV12: pre_pulse = (st.pre_cnt % 6'(DIV_A)) == 6'(DIV_A - 1);
      PRE_DIV4: pre_pulse = (st.pre_cnt % 6'(DIV_B)) == 6'(DIV_B - 1);
      PRE_DIV48: pre_pulse = (st.pre_cnt == PRE_LAST);
      default: pre_pulse = ext_rose && (st.ext_cnt == EXT_LAST);
    endcase
    next_st.pre_tick = pre_pulse;  // [R24]

    // Gate pins at their configured polarity
    g0_active = (t0_gate_enable_level == ext_irq0_polarity);
    g1_active = (t1_gate_enable_level == ext_irq1_polarity);

    // Timer 0 enable and tick selection
    t0_run = st.run_flag[RF_T0_RUN] & (~st.mode[MD_T0_GATE] | g0_active);  // [R10]
    if (st.mode[MD_T0_CNT]) begin
      t0_tick = t0_pin_fell;  // [R1]
    end else if (st.clk_sel[CKS_T0]) begin
      t0_tick = 1'b1;  // [R5]
    end else begin
      t0_tick = st.pre_tick;  // [R5]
    end

    // Split high byte: timer only, system or prescaled tick
    h0_tick = st.clk_sel[CKS_T0] ? 1'b1 : st.pre_tick;
    h0_inc = split & st.run_flag[RF_T1_RUN] & h0_tick;  // [R17]

    // Timer 1 enable and tick selection
    if (split) begin
      t1_run = (t1_mode != MODE_SPLIT);  // [R19]
    end else begin
      t1_run = st.run_flag[RF_T1_RUN] & (~st.mode[MD_T1_GATE] | g1_active)
        & (t1_mode != MODE_SPLIT);  // [R12]
    end
    if (st.mode[MD_T1_CNT] && !split) begin
      t1_tick = t1_pin_fell;  // [R1]
    end else if (st.clk_sel[CKS_T1]) begin
      t1_tick = 1'b1;  // [R4]
    end else begin
      t1_tick = st.pre_tick;  // [R18]
    end

    // Timer 0 counting
    if (split) begin
      r0[15:8] = st.t0_high + {7'h00, h0_inc};
      r0[7:0] = st.t0_low + {7'h00, t0_run & t0_tick};  // [R16]
      r0[16] = t0_run & t0_tick & (&st.t0_low);  // [R16]
      t1_set = h0_inc & (&st.t0_high);  // [R17]
    end else begin
      r0 = count_step(t0_mode, st.t0_high, st.t0_low, t0_run & t0_tick);  // [R11]
    end
    t0_set = r0[16];

    // Timer 1 counting
    r1 = count_step(t1_mode, st.t1_high, st.t1_low, t1_run & t1_tick);  // [R12]
    t1_wrap = r1[16];
    t1_set = t1_set | (~split & t1_wrap);  // [R18]
    next_st.t1_ovf = t1_wrap;  // [R18]

    next_st.t0_high = r0[15:8];
    next_st.t0_low = r0[7:0];
    next_st.t1_high = r1[15:8];
    next_st.t1_low = r1[7:0];

    // Register writes take precedence over counting
    if (sfr_wr) begin
      if (sfr_addr == ADDR_CLK_SELECT) begin
        next_st.clk_sel = sfr_wdata[5:0];  // [R6]
      end else if (sfr_addr == ADDR_RUN_FLAG) begin
        next_st.run_flag = sfr_wdata;  // [R11]
      end else if (sfr_addr == ADDR_MODE) begin
        next_st.mode = sfr_wdata;
      end else if (sfr_addr == ADDR_T0_LOW) begin
        next_st.t0_low = sfr_wdata;  // [R15]
      end else if (sfr_addr == ADDR_T1_LOW) begin
        next_st.t1_low = sfr_wdata;
      end else if (sfr_addr == ADDR_T0_HIGH) begin
        next_st.t0_high = sfr_wdata;
      end else if (sfr_addr == ADDR_T1_HIGH) begin
        next_st.t1_high = sfr_wdata;
      end
    end

    // Overflow flags: ack clears, hardware set wins over any clear
    if (t0_irq_ack) begin
      next_st.run_flag[RF_T0_FLAG] = 1'b0;  // [R22]
    end
    if (t1_irq_ack) begin
      next_st.run_flag[RF_T1_FLAG] = 1'b0;  // [R22]
    end
    if (t0_set) begin
      next_st.run_flag[RF_T0_FLAG] = 1'b1;  // [R9]
    end
    if (t1_set) begin
      next_st.run_flag[RF_T1_FLAG] = 1'b1;  // [R22]
    end

    // Read data, captured on the read strobe
    if (sfr_addr == ADDR_CLK_SELECT) begin
      rd = {2'b00, st.clk_sel};  // [R6]
    end else if (sfr_addr == ADDR_RUN_FLAG) begin
      rd = st.run_flag;
    end else if (sfr_addr == ADDR_MODE) begin
      rd = st.mode;
    end else if (sfr_addr == ADDR_T0_LOW) begin
      rd = st.t0_low;
    end else if (sfr_addr == ADDR_T1_LOW) begin
      rd = st.t1_low;
    end else if (sfr_addr == ADDR_T0_HIGH) begin
      rd = st.t0_high;
    end else if (sfr_addr == ADDR_T1_HIGH) begin
      rd = st.t1_high;
    end else begin
      rd = 8'h00;
    end
    next_st.rdata = sfr_rd ? rd : st.rdata;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st <= '{clk_sel: RST_CLK_SELECT, run_flag: RST_RUN_FLAG, mode: RST_MODE,
        t0_low: RST_COUNT, t0_high: RST_COUNT, t1_low: RST_COUNT, t1_high: RST_COUNT,
        pre_cnt: 6'h00, ext_cnt: 3'h0, pre_tick: 1'b0, t1_ovf: 1'b0,
        rdata: 8'h00};
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign sfr_rdata = st.rdata;
  assign t0_irq_req = st.run_flag[RF_T0_FLAG] & t0_irq_enable;  // [R20]
  assign t1_irq_req = st.run_flag[RF_T1_FLAG] & t1_irq_enable;  // [R20]
  assign t1_overflow_tick = st.t1_ovf;
  assign prescaled_tick = st.pre_tick;
  assign t2_high_system_clock_select = st.clk_sel[CKS_T2_HIGH];  // [R7]
  assign t2_low_system_clock_select = st.clk_sel[CKS_T2_LOW];  // [R7]

endmodule : ttc_timer01

// >>> verification/ttc_timer01_props.sv
`timescale 1ns/100ps

module ttc_timer01_props import ttc_pkg::*; (
  input wire logic clock, // System clock
  input wire logic rst_b, // Async reset, active low
  input wire logic [7:0] sfr_addr, // Register address
  input wire logic sfr_wr, // Write strobe
  input wire logic sfr_rd, // Read strobe
  input wire logic [7:0] sfr_wdata, // Write data
  input wire logic [7:0] sfr_rdata, // Read data
  input wire logic t0_irq_enable, // Timer 0 enable
  input wire logic t1_irq_enable, // Timer 1 enable
  input wire logic t0_irq_ack, // Timer 0 vector taken
  input wire logic t0_irq_req, // Timer 0 request
  input wire logic t1_irq_req, // Timer 1 request
  input wire logic prescaled_tick, // Prescaler pulse
  input wire logic t2_high_system_clock_select, // Bit 5 copy
  input wire logic t2_low_system_clock_select // Bit 4 copy
);
  logic [1:0] pre_sel;

  // --------------------
  // Helper state
  // --------------------
  // Shadow of the prescale field, taken from register writes
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pre_sel <= 2'h0;
    end else if (sfr_wr && sfr_addr == ADDR_CLK_SELECT) begin
      pre_sel <= sfr_wdata[1:0];
    end
  end

  // --------------------
  // Properties
  // --------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  // Mode register write, then a read two cycles later
  sequence s_mode_wr;
    sfr_wr && sfr_addr == ADDR_MODE;
  endsequence
  sequence s_mode_rd;
    sfr_rd && !sfr_wr && sfr_addr == ADDR_MODE;
  endsequence

  a_top_bits_zero: assert property (
    sfr_rd && sfr_addr == ADDR_CLK_SELECT |=> sfr_rdata[7:6] == 2'h0)
    else $error("clock select top bits not zero");
  a_t2_select_echo: assert property (
    sfr_wr && sfr_addr == ADDR_CLK_SELECT |=>
    {t2_high_system_clock_select, t2_low_system_clock_select} == $past(sfr_wdata[5:4]))
    else $error("timer 2 clock selects differ from write");
  a_mode_readback: assert property (
    s_mode_wr ##2 s_mode_rd |=> sfr_rdata == $past(sfr_wdata, 3))
    else $error("mode register readback differs");
  a_t0_req_masked: assert property (
    !t0_irq_enable |-> !t0_irq_req)
    else $error("timer 0 request while disabled");
  a_t1_req_masked: assert property (
    !t1_irq_enable |-> !t1_irq_req)
    else $error("timer 1 request while disabled");
  a_flag_sticky: assert property (
    t0_irq_req && !t0_irq_ack && !(sfr_wr && sfr_addr == ADDR_RUN_FLAG)
    ##1 t0_irq_enable |-> t0_irq_req)
    else $error("timer 0 flag dropped without clear");
  a_tick_single: assert property (
    prescaled_tick |=> !prescaled_tick)
    else $error("prescaled tick longer than one cycle");
  a_div4_spacing: assert property (
    prescaled_tick && pre_sel == PRE_DIV4 |=> !prescaled_tick [*3])
    else $error("divide by 4 ticks too close");
endmodule : ttc_timer01_props

bind ttc_timer01 ttc_timer01_props u_props (
  .clock(clock), .rst_b(rst_b), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
  .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
  .t0_irq_enable(t0_irq_enable), .t1_irq_enable(t1_irq_enable),
  .t0_irq_ack(t0_irq_ack), .t0_irq_req(t0_irq_req), .t1_irq_req(t1_irq_req),
  .prescaled_tick(prescaled_tick), .t2_high_system_clock_select(t2_high_system_clock_select),
  .t2_low_system_clock_select(t2_low_system_clock_select)
);

// >>> verification/ttc_pin_model.sv
`timescale 1ns/100ps

module ttc_pin_model (
  input wire logic clock, // System clock
  input wire logic ext_run, // Let the external clock toggle
  output logic t0_count_pin, // Timer 0 event pin
  output logic t1_count_pin, // Timer 1 event pin
  output logic ext_irq0_input, // Timer 0 gate pin
  output logic ext_irq1_input, // Timer 1 gate pin
  output logic external_osc_clock // External clock
);
  int ext_cnt;

  // Idle levels: count pins high, gates low, clock low
  initial begin
    ext_cnt = 0;
    t0_count_pin = 1'b1;
    t1_count_pin = 1'b1;
    ext_irq0_input = 1'b0;
    ext_irq1_input = 1'b0;
    external_osc_clock = 1'b0;
  end

  // External clock, five system clocks per level
  always @(posedge clock) begin
    if (ext_run) begin
      ext_cnt <= (ext_cnt == 4) ? 0 : ext_cnt + 1;
      if (ext_cnt == 4) begin
        external_osc_clock <= ~external_osc_clock;
      end
    end
  end

  // Gate levels, then time for the pin synchronisers to settle
  task automatic gates(input logic g0, input logic g1);
    @(posedge clock);
    #1;
    ext_irq0_input = g0;
    ext_irq1_input = g1;
    repeat (6) @(posedge clock);
  endtask : gates

  // Falling edges on the chosen pins, each level held two clocks
  task automatic falls(input logic [1:0] pins, input int n);
    repeat (n) begin
      @(posedge clock);
      #1;
      t0_count_pin = !pins[0];
      t1_count_pin = !pins[1];
      repeat (2) @(posedge clock);
      #1;
      t0_count_pin = 1'b1;
      t1_count_pin = 1'b1;
      @(posedge clock);
    end
    repeat (6) @(posedge clock);
  endtask : falls
endmodule : ttc_pin_model

// >>> verification/ttc_timer01_test.sv
`timescale 1ns/100ps

module ttc_timer01_test import ttc_pkg::*;;
  logic clock;
  logic rst_b;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata;
  logic t0_pin, t1_pin, t0_gate_enable, t1_gate_enable, ext_clk;
  logic t0_irq_enable = 1'b0;
  logic t1_irq_enable = 1'b0;
  logic t0_irq_ack = 1'b0;
  logic t1_irq_ack = 1'b0;
  logic ext_run = 1'b0;
  logic t0_irq_req, t1_irq_req, t1_tick, pre_tick, t2_hi, t2_lo;
  logic [7:0] cks [5] = '{8'h08, 8'h00, 8'h01, 8'h02, 8'h03};
  logic [7:0] per [5] = '{8'h02, 8'h18, 8'h08, 8'h60, 8'ha0};
  logic [7:0] d;
  int err_total = 0;
  int total_checks = 0;
  int n;

  ttc_timer01 dut (
    .clock(clock), .rst_b(rst_b), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .t0_count_pin(t0_pin), .t1_count_pin(t1_pin), .ext_irq0_input(t0_gate_enable),
    .ext_irq1_input(t1_gate_enable), .external_osc_clock(ext_clk),
    .ext_irq0_polarity(1'b1), .ext_irq1_polarity(1'b0),
    .t0_irq_enable(t0_irq_enable), .t1_irq_enable(t1_irq_enable),
    .t0_irq_ack(t0_irq_ack), .t1_irq_ack(t1_irq_ack), .t0_irq_req(t0_irq_req),
    .t1_irq_req(t1_irq_req), .t1_overflow_tick(t1_tick), .prescaled_tick(pre_tick),
    .t2_high_system_clock_select(t2_hi), .t2_low_system_clock_select(t2_lo)
  );

  ttc_pin_model u_pins (
    .clock(clock), .ext_run(ext_run), .t0_count_pin(t0_pin), .t1_count_pin(t1_pin),
    .ext_irq0_input(t0_gate_enable), .ext_irq1_input(t1_gate_enable), .external_osc_clock(ext_clk)
  );

  // --------------------
  // Bus and check tasks
  // --------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock);
    #1;
    sfr_addr = a;
    sfr_wdata = v;
    sfr_wr = 1'b1;
    @(posedge clock);
    #1;
    sfr_wr = 1'b0;
  endtask : wr

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Read one register; data is valid after the strobe edge
  task automatic rdchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clock);
    #1;
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(posedge clock);
    #1;
    sfr_rd = 1'b0;
    d = sfr_rdata;
    chk($sformatf("register %h", a), d & m, e);
  endtask : rdchk

  task automatic ack(input logic which);
    @(posedge clock);
    #1;
    t0_irq_ack = !which;
    t1_irq_ack = which;
    @(posedge clock);
    #1;
    t0_irq_ack = 1'b0;
    t1_irq_ack = 1'b0;
  endtask : ack

  // Cycles from the previous timer 1 overflow pulse to the next
  task automatic wait_tick();
    n = 0;
    do begin
      @(posedge clock);
      #1;
      n++;
    end while (t1_tick !== 1'b1 && n < 400);
    if (n >= 400) begin
      err_total++;
      $display("Error overflow tick expected pulse seen none");
      close_out();
    end
  endtask : wait_tick

  task automatic close_out();
    $display("Checks %0d, mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out

  // --------------------
  // Sequence
  // --------------------
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  initial begin
    rst_b = 1'b0;
    repeat (12) @(posedge clock);
    #1;
    rst_b = 1'b1;
    for (int a = 8'h88; a <= 8'h8e; a++) begin
      rdchk(8'(a), 8'hff, 8'h00);
    end
    wr(ADDR_CLK_SELECT, 8'he0);
    rdchk(ADDR_CLK_SELECT, 8'hff, 8'h20);
    chk("t2 selects", 8'({t2_hi, t2_lo}), 8'h02);
    wr(ADDR_CLK_SELECT, 8'hd0);
    chk("t2 selects", 8'({t2_hi, t2_lo}), 8'h01);
    wr(ADDR_MODE, 8'h5a);
    rdchk(ADDR_MODE, 8'hff, 8'h5a);
    rdchk(8'h90, 8'hff, 8'h00);
    $display("Test registers done");
    wr(ADDR_MODE, 8'hdd);
    wr(ADDR_RUN_FLAG, 8'h50);
    u_pins.gates(1'b1, 1'b0);
    u_pins.falls(2'h3, 10);
    rdchk(ADDR_T0_LOW, 8'hff, 8'h0a);
    rdchk(ADDR_T1_LOW, 8'hff, 8'h0a);
    u_pins.gates(1'b0, 1'b1);
    u_pins.falls(2'h3, 5);
    rdchk(ADDR_T0_LOW, 8'hff, 8'h0a);
    rdchk(ADDR_T1_LOW, 8'hff, 8'h0a);
    u_pins.gates(1'b1, 1'b0);
    wr(ADDR_RUN_FLAG, 8'h00);
    u_pins.falls(2'h3, 2);
    wr(ADDR_RUN_FLAG, 8'h50);
    rdchk(ADDR_T0_LOW, 8'hff, 8'h0a);
    u_pins.falls(2'h1, 1);
    rdchk(ADDR_T0_LOW, 8'hff, 8'h0b);
    $display("Test counting done");
    wr(ADDR_MODE, 8'h04);
    wr(ADDR_RUN_FLAG, 8'h10);
    wr(ADDR_T0_HIGH, 8'hff);
    wr(ADDR_T0_LOW, 8'h1f);
    u_pins.falls(2'h1, 1);
    rdchk(ADDR_T0_HIGH, 8'hff, 8'h00);
    rdchk(ADDR_T0_LOW, 8'h1f, 8'h00);
    rdchk(ADDR_RUN_FLAG, 8'h20, 8'h20);
    chk("t0 request", 8'(t0_irq_req), 8'h00);
    t0_irq_enable = 1'b1;
    @(posedge clock);
    #1;
    chk("t0 request", 8'(t0_irq_req), 8'h01);
    ack(1'b0);
    chk("t0 request", 8'(t0_irq_req), 8'h00);
    $display("Test overflow done");
    t1_irq_enable = 1'b1;
    wr(ADDR_CLK_SELECT, 8'h04);
    wr(ADDR_T0_HIGH, 8'hf0);
    wr(ADDR_T0_LOW, 8'h00);
    wr(ADDR_MODE, 8'h37);
    wr(ADDR_RUN_FLAG, 8'h40);
    rdchk(ADDR_T1_LOW, 8'hff, 8'h0a);
    n = d;
    for (int k = 0; k < 40 && t1_irq_req !== 1'b1; k++) begin
      @(posedge clock);
      #1;
    end
    chk("t1 request", 8'(t1_irq_req), 8'h01);
    rdchk(ADDR_T1_LOW, 8'hff, 8'(n));
    rdchk(ADDR_T0_LOW, 8'hff, 8'h00);
    ack(1'b1);
    chk("t1 request", 8'(t1_irq_req), 8'h00);
    wr(ADDR_RUN_FLAG, 8'h10);
    u_pins.falls(2'h1, 3);
    rdchk(ADDR_T0_LOW, 8'hff, 8'h03);
    wr(ADDR_T1_HIGH, 8'hfe);
    wr(ADDR_T1_LOW, 8'hfe);
    wr(ADDR_MODE, 8'h27);
    wait_tick();
    rdchk(ADDR_RUN_FLAG, 8'h80, 8'h00);
    $display("Test split done");
    wr(ADDR_MODE, 8'h20);
    wr(ADDR_RUN_FLAG, 8'h40);
    for (int i = 0; i < 5; i++) begin
      wr(ADDR_CLK_SELECT, cks[i]);
      ext_run = (i == 4);
      wait_tick();
      wait_tick();
      wait_tick();
      chk("t1 period", 8'(n), per[i]);
    end
    rdchk(ADDR_RUN_FLAG, 8'h80, 8'h80);
    rdchk(ADDR_T1_HIGH, 8'hff, 8'hfe);
    // Timer 0 as 16-bit timer on the system clock: 16 counts to carry out
    wr(ADDR_MODE, 8'h01);
    wr(ADDR_CLK_SELECT, 8'h04);
    wr(ADDR_T0_HIGH, 8'hff);
    wr(ADDR_T0_LOW, 8'hf0);
    wr(ADDR_RUN_FLAG, 8'h10);
    repeat (20) @(posedge clock);
    rdchk(ADDR_RUN_FLAG, 8'h20, 8'h20);
    rdchk(ADDR_T0_HIGH, 8'hff, 8'h00);
    $display("Test clocks done");
    close_out();
  end
endmodule : ttc_timer01_test
